// ---- verilog/plk_consts.vh ----
`ifndef PLK_CONSTS_VH
`define PLK_CONSTS_VH

// Register offsets
`define PLK_ADDR_DIV_LO      8'h5c
`define PLK_ADDR_DIV_HI      8'h5d
`define PLK_ADDR_CONFIG      8'h5e
`define PLK_ADDR_CONTROL     8'h5f
`define PLK_ADDR_IRQ_STATUS  8'h60
`define PLK_ADDR_IRQ_MASK    8'h61

// Reset values and the divider minimum
`define PLK_DIV_LO_RST       8'h02
`define PLK_DIV_RST          11'h002
`define PLK_DIV_MIN          11'h002

// Field positions
`define PLK_CFG_PUMP_HI      7
`define PLK_CFG_PUMP_LO      6
`define PLK_CFG_LDS_HI       3
`define PLK_CFG_LDS_LO       2
`define PLK_CFG_SRC_HI       1
`define PLK_CFG_SRC_LO       0
`define PLK_CTL_ENABLE       0
`define PLK_CTL_LOCK         1
`define PLK_IRQ_LOCK         0
`define PLK_IRQ_UNLOCK       1

// Clock source codes
`define PLK_SRC_CRYSTAL_REFERENCE         2'h0
`define PLK_SRC_LOOP         2'h1
`define PLK_SRC_RTC          2'h2
`define PLK_SRC_RSVD         2'h3

// Lock windows of 20 ns and 400 ns in 8 ns clock cycles, rounded down
// so that a borderline error never counts as inside the window
`define PLK_WIN_SHORT_CYC    6'h02
`define PLK_WIN_LONG_CYC     6'h32
`define PLK_COUNT_SHORT      5'h08
`define PLK_COUNT_LONG       5'h10

`endif

// ---- verilog/plk_loop_core.v ----
`timescale 1ns/1ps
`include "plk_consts.vh"

module plk_loop_core (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_n_i,
    // Synchronised clock levels
    input  wire        ref_i,
    input  wire        vco_i,
    // Settings
    input  wire        enable_i,
    input  wire [10:0] div_i,
    input  wire [1:0]  lds_i,
    // Results
    output reg         up_o,
    output reg         dn_o,
    output reg         fb_o,
    output reg         lock_o
);

    localparam [5:0] WIN_SHORT = `PLK_WIN_SHORT_CYC;
    localparam [5:0] WIN_LONG  = `PLK_WIN_LONG_CYC;
    localparam [5:0] ERR_MAX   = 6'h3f;

    reg        ref_d_reg;
    reg        vco_d_reg;
    reg        fb_d_reg;
    reg [10:0] cnt_reg;
    reg [5:0]  err_reg;
    reg [4:0]  good_reg;

    reg [10:0] div_eff;
    reg [10:0] cnt_next;
    reg        fb_next;
    reg        up_set;
    reg        dn_set;
    reg        done;
    reg [5:0]  window;
    reg [4:0]  need;
    reg        bad;
    reg [5:0]  err_next;
    reg [4:0]  good_next;

    always @* begin
        div_eff = (div_i < `PLK_DIV_MIN) ? `PLK_DIV_MIN : div_i;
        cnt_next = cnt_reg;
        if (vco_i && !vco_d_reg) begin
            cnt_next = (cnt_reg == 11'h000) ? div_eff - 11'h001 : cnt_reg - 11'h001;
        end
        fb_next = (cnt_next >= {1'b0, div_eff[10:1]});
        // Falling edges open the error pulses; both seen closes them
        up_set = up_o | (ref_d_reg & !ref_i);
        dn_set = dn_o | (fb_d_reg & !fb_o);
        done = up_set & dn_set;
        window = lds_i[1] ? WIN_LONG : WIN_SHORT;
        need = lds_i[0] ? `PLK_COUNT_LONG : `PLK_COUNT_SHORT;
        bad = (up_set | dn_set) && (err_reg > window);
        err_next = err_reg;
        if (done) begin
            err_next = 6'h00;
        end else if ((up_set | dn_set) && (err_reg != ERR_MAX)) begin
            err_next = err_reg + 6'h01;
        end
        good_next = good_reg;
        if (bad) begin
            good_next = 5'h00;
        end else if (done && (good_reg < need)) begin
            good_next = good_reg + 5'h01;
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_d_reg <= 1'b0;
            vco_d_reg <= 1'b0;
            fb_d_reg  <= 1'b0;
            cnt_reg   <= 11'h000;
            err_reg   <= 6'h00;
            good_reg  <= 5'h00;
            up_o      <= 1'b0;
            dn_o      <= 1'b0;
            fb_o      <= 1'b0;
            lock_o    <= 1'b0;
        end else if (!enable_i) begin
            ref_d_reg <= ref_i;
            vco_d_reg <= vco_i;
            fb_d_reg  <= 1'b0;
            cnt_reg   <= 11'h000;
            err_reg   <= 6'h00;
            good_reg  <= 5'h00;
            up_o      <= 1'b0;
            dn_o      <= 1'b0;
            fb_o      <= 1'b0;
            lock_o    <= 1'b0;
        end else begin
            ref_d_reg <= ref_i;
            vco_d_reg <= vco_i;
            fb_d_reg  <= fb_o;
            cnt_reg   <= cnt_next;
            fb_o      <= fb_next;
            err_reg   <= err_next;
            good_reg  <= good_next;
            up_o      <= up_set & !done;
            dn_o      <= dn_set & !done;
            lock_o    <= (good_next >= need);
        end
    end

endmodule

// ---- verilog/plk_clock_ctrl.v ----
`timescale 1ns/1ps
`include "plk_consts.vh"

module plk_clock_ctrl (
    // Clock and reset
    input  wire       CLOCK_I,
    input  wire       RST_B_I,
    // Register port
    input  wire [7:0] ADDR_I,
    input  wire [7:0] WR_DATA_I,
    input  wire       WR_STB_I,
    input  wire       RD_STB_I,
    output reg  [7:0] RD_DATA_O,
    // Clocks sampled from the analog side
    input  wire       CRYSTAL_REFERENCE_CLK_I,
    input  wire       VCO_CLK_I,
    input  wire       RTC_CLK_I,
    // Charge pump and loop
    output wire       CP_UP_O,
    output wire       CP_DN_O,
    output reg  [1:0] CP_CURRENT_O,
    output reg        LOOP_ENABLE_O,
    output wire       FB_DIV_O,
    // Clock gate enables
    output reg        SRC_CRYSTAL_REFERENCE_EN_O,
    output reg        SRC_LOOP_EN_O,
    output reg        SRC_RTC_EN_O,
    // Status
    output reg        LOCK_O,
    output reg        IRQ_O
);

    localparam [1:0] MX_RUN   = 2'h0;
    localparam [1:0] MX_STOP  = 2'h1;
    localparam [1:0] MX_START = 2'h2;

    function level_of;
        input [1:0] src;
        input [2:0] lv;
        begin
            case (src)
                `PLK_SRC_LOOP: level_of = lv[1];
                `PLK_SRC_RTC:  level_of = lv[2];
                default:       level_of = lv[0];
            endcase
        end
    endfunction

    function [2:0] gate_of;
        input [1:0] src;
        begin
            case (src)
                `PLK_SRC_LOOP: gate_of = 3'h2;
                `PLK_SRC_RTC:  gate_of = 3'h4;
                default:       gate_of = 3'h1;
            endcase
        end
    endfunction

    // Pin synchronisers: bit 0 crystal, 1 VCO, 2 RTC
    reg  [2:0]  pin_s1_reg;
    reg  [2:0]  pin_s2_reg;
    reg         lock_s1_reg;
    reg         lock_s2_reg;
    reg         lock_d_reg;

    reg  [7:0]  div_lo_reg;
    reg  [10:0] div_reg;
    reg  [1:0]  pump_reg;
    reg  [1:0]  lds_reg;
    reg  [1:0]  sel_reg;
    reg         en_reg;
    reg  [1:0]  stat_reg;
    reg  [1:0]  mask_reg;

    reg  [1:0]  mx_state_reg;
    reg  [1:0]  cur_src_reg;
    reg  [1:0]  tgt_src_reg;
    reg  [2:0]  gate_reg;

    wire        core_lock;
    wire        wr_cfg  = WR_STB_I && (ADDR_I == `PLK_ADDR_CONFIG);
    wire        wr_ctl  = WR_STB_I && (ADDR_I == `PLK_ADDR_CONTROL);
    wire        wr_stat = WR_STB_I && (ADDR_I == `PLK_ADDR_IRQ_STATUS);
    wire        wr_mask = WR_STB_I && (ADDR_I == `PLK_ADDR_IRQ_MASK);
    wire        locked  = en_reg && lock_s2_reg;

    reg  [1:0]  sel_next;
    reg  [1:0]  stat_set;
    reg  [1:0]  stat_next;
    reg  [7:0]  rd_val;

    plk_loop_core u_core (
        .clk_i    (CLOCK_I),
        .rst_n_i  (RST_B_I),
        .ref_i    (pin_s2_reg[0]),
        .vco_i    (pin_s2_reg[1]),
        .enable_i (en_reg),
        .div_i    (div_reg),
        .lds_i    (lds_reg),
        .up_o     (CP_UP_O),
        .dn_o     (CP_DN_O),
        .fb_o     (FB_DIV_O),
        .lock_o   (core_lock)
    );

    always @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pin_s1_reg  <= 3'h0;
            pin_s2_reg  <= 3'h0;
            lock_s1_reg <= 1'b0;
            lock_s2_reg <= 1'b0;
            lock_d_reg  <= 1'b0;
        end else begin
            pin_s1_reg  <= {RTC_CLK_I, VCO_CLK_I, CRYSTAL_REFERENCE_CLK_I};
            pin_s2_reg  <= pin_s1_reg;
            lock_s1_reg <= core_lock;
            lock_s2_reg <= lock_s1_reg;
            lock_d_reg  <= lock_s2_reg;
        end
    end

    always @* begin
        sel_next = sel_reg;
        if (wr_cfg) begin
            case (WR_DATA_I[`PLK_CFG_SRC_HI:`PLK_CFG_SRC_LO])
                `PLK_SRC_CRYSTAL_REFERENCE: sel_next = `PLK_SRC_CRYSTAL_REFERENCE;
                `PLK_SRC_RTC:  sel_next = `PLK_SRC_RTC;
                `PLK_SRC_LOOP: sel_next = locked ? `PLK_SRC_LOOP : sel_reg;
                default:       sel_next = sel_reg;
            endcase
        end
        // Losing lock or disabling drops back to the crystal
        if ((sel_next == `PLK_SRC_LOOP) && !locked) begin
            sel_next = `PLK_SRC_CRYSTAL_REFERENCE;
        end
        stat_set = 2'h0;
        stat_set[`PLK_IRQ_LOCK]   = lock_s2_reg && !lock_d_reg;
        stat_set[`PLK_IRQ_UNLOCK] = !lock_s2_reg && lock_d_reg;
        // Set wins over a write-one-to-clear in the same cycle
        stat_next = (stat_reg & ~(wr_stat ? WR_DATA_I[1:0] : 2'h0)) | stat_set;
        case (ADDR_I)
            `PLK_ADDR_CONFIG:     rd_val = {pump_reg, 2'h0, lds_reg, sel_reg};
            `PLK_ADDR_CONTROL:    rd_val = {6'h00, lock_s2_reg, en_reg};
            `PLK_ADDR_IRQ_STATUS: rd_val = {6'h00, stat_reg};
            `PLK_ADDR_IRQ_MASK:   rd_val = {6'h00, mask_reg};
            default:              rd_val = 8'h00;
        endcase
    end

    always @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            div_lo_reg    <= `PLK_DIV_LO_RST;
            div_reg       <= `PLK_DIV_RST;
            pump_reg      <= 2'h0;
            lds_reg       <= 2'h0;
            sel_reg       <= `PLK_SRC_CRYSTAL_REFERENCE;
            en_reg        <= 1'b0;
            stat_reg      <= 2'h0;
            mask_reg      <= 2'h0;
            RD_DATA_O     <= 8'h00;
            CP_CURRENT_O  <= 2'h0;
            LOOP_ENABLE_O <= 1'b0;
            LOCK_O        <= 1'b0;
            IRQ_O         <= 1'b0;
        end else begin
            // Divider and loop settings only change while the loop is off
            if (WR_STB_I && (ADDR_I == `PLK_ADDR_DIV_LO) && !en_reg) begin
                div_lo_reg <= WR_DATA_I;
            end
            if (WR_STB_I && (ADDR_I == `PLK_ADDR_DIV_HI) && !en_reg) begin
                div_reg <= {WR_DATA_I[2:0], div_lo_reg};
            end
            if (wr_cfg && !en_reg) begin
                pump_reg <= WR_DATA_I[`PLK_CFG_PUMP_HI:`PLK_CFG_PUMP_LO];
                lds_reg  <= WR_DATA_I[`PLK_CFG_LDS_HI:`PLK_CFG_LDS_LO];
            end
            if (wr_ctl) begin
                en_reg <= WR_DATA_I[`PLK_CTL_ENABLE];
            end
            if (wr_mask) begin
                mask_reg <= WR_DATA_I[1:0];
            end
            sel_reg       <= sel_next;
            stat_reg      <= stat_next;
            RD_DATA_O     <= RD_STB_I ? rd_val : 8'h00;
            CP_CURRENT_O  <= pump_reg;
            LOOP_ENABLE_O <= en_reg;
            LOCK_O        <= lock_s2_reg;
            IRQ_O         <= |(stat_next & mask_reg);
        end
    end

    // Break-before-make switch. The sampled level lags the real clock by
    // two cycles, so gating cells outside must also retime to their clock.
    always @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            mx_state_reg  <= MX_RUN;
            cur_src_reg   <= `PLK_SRC_CRYSTAL_REFERENCE;
            tgt_src_reg   <= `PLK_SRC_CRYSTAL_REFERENCE;
            gate_reg      <= 3'h1;
            SRC_CRYSTAL_REFERENCE_EN_O <= 1'b1;
            SRC_LOOP_EN_O <= 1'b0;
            SRC_RTC_EN_O  <= 1'b0;
        end else begin
            case (mx_state_reg)
                MX_RUN: begin
                    if (sel_reg != cur_src_reg) begin
                        tgt_src_reg  <= sel_reg;
                        mx_state_reg <= MX_STOP;
                    end
                end
                MX_STOP: begin
                    if (!level_of(cur_src_reg, pin_s2_reg)) begin
                        gate_reg     <= 3'h0;
                        mx_state_reg <= MX_START;
                    end
                end
                MX_START: begin
                    if ((tgt_src_reg == `PLK_SRC_LOOP) && !locked) begin
                        tgt_src_reg <= `PLK_SRC_CRYSTAL_REFERENCE;
                    end else if (!level_of(tgt_src_reg, pin_s2_reg)) begin
                        gate_reg     <= gate_of(tgt_src_reg);
                        cur_src_reg  <= tgt_src_reg;
                        mx_state_reg <= MX_RUN;
                    end
                end
                default: begin
                    mx_state_reg <= MX_RUN;
                end
            endcase
            SRC_CRYSTAL_REFERENCE_EN_O <= gate_reg[0];
            SRC_LOOP_EN_O <= gate_reg[1];
            SRC_RTC_EN_O  <= gate_reg[2];
        end
    end

endmodule

// ---- sim/plk_monitor.sv ----
`timescale 1ns/1ps
module plk_monitor (
    input logic       CLOCK_I,
    input logic       RST_B_I,
    input logic [7:0] ADDR_I,
    input logic       WR_STB_I,
    input logic       RD_STB_I,
    input logic [7:0] RD_DATA_O,
    input logic [1:0] CP_CURRENT_O,
    input logic       LOOP_ENABLE_O,
    input logic       SRC_CRYSTAL_REFERENCE_EN_O,
    input logic       SRC_LOOP_EN_O,
    input logic       SRC_RTC_EN_O,
    input logic       LOCK_O,
    input logic       IRQ_O
);
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RST_B_I);

    sequence s_loop_ready;
        LOOP_ENABLE_O && LOCK_O;
    endsequence
    sequence s_cfg_written;
        ($past(WR_STB_I) && $past(ADDR_I) == 8'h5e) || ($past(WR_STB_I, 2) && $past(ADDR_I, 2) == 8'h5e);
    endsequence

    property p_one_gate;
        $onehot0({SRC_CRYSTAL_REFERENCE_EN_O, SRC_LOOP_EN_O, SRC_RTC_EN_O});
    endproperty
    a_one_gate: assert property (p_one_gate) else $error("two clock gates open");
    property p_break_make;
        $rose(SRC_LOOP_EN_O) |-> !$past(SRC_CRYSTAL_REFERENCE_EN_O) && !$past(SRC_RTC_EN_O);
    endproperty
    a_break_make: assert property (p_break_make) else $error("loop gate opened early");
    property p_loop_lock;
        $rose(SRC_LOOP_EN_O) |-> s_loop_ready;
    endproperty
    a_loop_lock: assert property (p_loop_lock) else $error("loop selected unlocked");
    property p_reset_state;
        $rose(RST_B_I) |-> SRC_CRYSTAL_REFERENCE_EN_O && !LOOP_ENABLE_O && !LOCK_O && !IRQ_O;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
    property p_lock_en;
        $rose(LOCK_O) |-> LOOP_ENABLE_O;
    endproperty
    a_lock_en: assert property (p_lock_en) else $error("lock while disabled");
    property p_pump_write;
        $changed(CP_CURRENT_O) |-> s_cfg_written;
    endproperty
    a_pump_write: assert property (p_pump_write) else $error("pump code moved alone");
    property p_irq_cause;
        $rose(IRQ_O) |-> LOCK_O != $past(LOCK_O, 3) || $past(WR_STB_I) || $past(WR_STB_I, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without lock edge");
    property p_rd_idle;
        RD_DATA_O != 8'h00 |-> $past(RD_STB_I);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
endmodule

bind plk_clock_ctrl plk_monitor u_mon (
    .CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .WR_STB_I(WR_STB_I),
    .RD_STB_I(RD_STB_I), .RD_DATA_O(RD_DATA_O), .CP_CURRENT_O(CP_CURRENT_O),
    .LOOP_ENABLE_O(LOOP_ENABLE_O), .SRC_CRYSTAL_REFERENCE_EN_O(SRC_CRYSTAL_REFERENCE_EN_O),
    .SRC_LOOP_EN_O(SRC_LOOP_EN_O), .SRC_RTC_EN_O(SRC_RTC_EN_O), .LOCK_O(LOCK_O), .IRQ_O(IRQ_O)
);

// ---- sim/plk_analog_model.sv ----
`timescale 1ns/1ps
module plk_analog_model (
    input  logic        loop_en_i,
    input  logic        stall_i,
    input  logic [10:0] ratio_i,
    output logic        crystal_reference_o,
    output logic        vco_o,
    output logic        rtc_o
);
    initial begin
        crystal_reference_o = 1'b0;
        forever #160 crystal_reference_o = ~crystal_reference_o;
    end
    // Phase unrelated to the crystal on purpose
    initial begin
        rtc_o = 1'b0;
        forever #510 rtc_o = ~rtc_o;
    end
    // Stands low when off or stalled; a stall is how the bench forces loss of lock
    initial begin
        vco_o = 1'b0;
        forever begin
            if (loop_en_i && !stall_i) begin
                #(160.0 / ratio_i);
                vco_o = ~vco_o;
            end else begin
                vco_o = 1'b0;
                #8;
            end
        end
    end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
    logic        CLOCK_I, RST_B_I, WR_STB_I, RD_STB_I, CRYSTAL_REFERENCE_CLK_I, VCO_CLK_I, RTC_CLK_I;
    logic [7:0]  ADDR_I, WR_DATA_I, RD_DATA_O, exp_v;
    logic [1:0]  CP_CURRENT_O;
    logic        CP_UP_O, CP_DN_O, LOOP_ENABLE_O, FB_DIV_O, LOCK_O, IRQ_O;
    logic        SRC_CRYSTAL_REFERENCE_EN_O, SRC_LOOP_EN_O, SRC_RTC_EN_O, vco_stall, rd_d, px, pf;
    logic [10:0] div_n;
    logic [7:0]  exp_q[$];
    int          miscompares, checks, seed, n, k, x, fb;

    plk_clock_ctrl uut (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I),
        .WR_DATA_I(WR_DATA_I), .WR_STB_I(WR_STB_I), .RD_STB_I(RD_STB_I), .RD_DATA_O(RD_DATA_O),
        .CRYSTAL_REFERENCE_CLK_I(CRYSTAL_REFERENCE_CLK_I), .VCO_CLK_I(VCO_CLK_I), .RTC_CLK_I(RTC_CLK_I), .CP_UP_O(CP_UP_O),
        .CP_DN_O(CP_DN_O), .CP_CURRENT_O(CP_CURRENT_O), .LOOP_ENABLE_O(LOOP_ENABLE_O),
        .FB_DIV_O(FB_DIV_O), .SRC_CRYSTAL_REFERENCE_EN_O(SRC_CRYSTAL_REFERENCE_EN_O), .SRC_LOOP_EN_O(SRC_LOOP_EN_O),
        .SRC_RTC_EN_O(SRC_RTC_EN_O), .LOCK_O(LOCK_O), .IRQ_O(IRQ_O));
    plk_analog_model u_ana (.loop_en_i(LOOP_ENABLE_O), .stall_i(vco_stall), .ratio_i(div_n),
        .crystal_reference_o(CRYSTAL_REFERENCE_CLK_I), .vco_o(VCO_CLK_I), .rtc_o(RTC_CLK_I));

    initial begin
        CLOCK_I = 1'b0;
        forever #4 CLOCK_I = ~CLOCK_I;
    end

    always @(posedge CLOCK_I) rd_d <= RD_STB_I;
    always @(negedge CLOCK_I) begin
        if (rd_d === 1'b1) begin
            exp_v = exp_q.pop_front();
            `CHK(RD_DATA_O, exp_v)
        end
    end

    task automatic complete_run();
        if (miscompares == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ADDR_I <= a;
        WR_DATA_I <= d;
        WR_STB_I <= 1'b1;
        RD_STB_I <= 1'b0;
        @(posedge CLOCK_I);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        ADDR_I <= a;
        RD_STB_I <= 1'b1;
        WR_STB_I <= 1'b0;
        exp_q.push_back(e);
        @(posedge CLOCK_I);
    endtask

    task automatic idle(input int c);
        WR_STB_I <= 1'b0;
        RD_STB_I <= 1'b0;
        repeat (c) @(posedge CLOCK_I);
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return LOCK_O;
            1: return SRC_LOOP_EN_O;
            2: return SRC_CRYSTAL_REFERENCE_EN_O;
            default: return SRC_RTC_EN_O;
        endcase
    endfunction

    task automatic wait_on(input int s, input logic v);
        int i;
        idle(0);
        for (i = 0; i < 6000 && pick(s) !== v; i++) @(negedge CLOCK_I);
        if (i == 6000) begin
            miscompares++;
            complete_run();
        end else begin
            @(posedge CLOCK_I);
        end
    endtask

    initial begin
        seed = 95;
        miscompares = 0;
        checks = 0;
        RST_B_I = 1'b0;
        WR_STB_I = 1'b0;
        RD_STB_I = 1'b0;
        ADDR_I = 8'h00;
        WR_DATA_I = 8'h00;
        vco_stall = 1'b0;
        div_n = 11'h002 + {9'h000, 2'($random(seed))};
        repeat (12) @(posedge CLOCK_I);
        RST_B_I <= 1'b1;
        @(posedge CLOCK_I);
        `CHK(SRC_CRYSTAL_REFERENCE_EN_O, 1'b1)
        `CHK(LOOP_ENABLE_O, 1'b0)
        rd(8'h5e, 8'h00);
        rd(8'h5f, 8'h00);
        rd(8'h5c, 8'h00);
        rd(8'h40, 8'h00);
        for (n = 0; n < 4; n++) begin
            wr(8'h5e, {n[1:0], 6'h00});
            idle(3);
            `CHK(CP_CURRENT_O, n[1:0])
        end
        wr(8'h5e, 8'hcb);
        rd(8'h5e, 8'hc8);
        wr(8'h5e, 8'h0a);
        wait_on(3, 1'b1);
        `CHK(SRC_CRYSTAL_REFERENCE_EN_O, 1'b0)
        rd(8'h5e, 8'h0a);
        wr(8'h5e, 8'h0c);
        wait_on(2, 1'b1);
        // Low byte first: the high byte write loads the whole divider
        wr(8'h5c, div_n[7:0]);
        wr(8'h5d, {5'h00, div_n[10:8]});
        wr(8'h61, 8'h03);
        wr(8'h5f, 8'h01);
        wr(8'h5e, 8'hcd);
        rd(8'h5e, 8'h0c);
        wait_on(0, 1'b1);
        rd(8'h5f, 8'h03);
        rd(8'h60, 8'h01);
        idle(1);
        `CHK(IRQ_O, 1'b1)
        x = 0;
        fb = 0;
        px = CRYSTAL_REFERENCE_CLK_I;
        pf = FB_DIV_O;
        for (k = 0; k < 1000 && x < 9; k++) begin
            @(negedge CLOCK_I);
            // Half-open window: a feedback edge seen with a reference edge counts at the end only
            if (x > 0 && pf && !FB_DIV_O) fb++;
            if (px && !CRYSTAL_REFERENCE_CLK_I) x++;
            px = CRYSTAL_REFERENCE_CLK_I;
            pf = FB_DIV_O;
        end
        @(posedge CLOCK_I);
        `CHK(fb, 8)
        wr(8'h60, 8'h01);
        rd(8'h60, 8'h00);
        idle(2);
        `CHK(IRQ_O, 1'b0)
        wr(8'h5e, 8'h0d);
        wait_on(1, 1'b1);
        `CHK(SRC_CRYSTAL_REFERENCE_EN_O, 1'b0)
        rd(8'h5e, 8'h0d);
        vco_stall <= 1'b1;
        wait_on(0, 1'b0);
        // Stalled feedback: the reference edge opened the up pulse and nothing closes it
        `CHK(CP_UP_O, 1'b1)
        `CHK(CP_DN_O, 1'b0)
        wait_on(2, 1'b1);
        rd(8'h5e, 8'h0c);
        rd(8'h60, 8'h02);
        idle(1);
        `CHK(IRQ_O, 1'b1)
        wr(8'h61, 8'h00);
        idle(3);
        `CHK(IRQ_O, 1'b0)
        RST_B_I <= 1'b0;
        idle(2);
        RST_B_I <= 1'b1;
        idle(1);
        rd(8'h5f, 8'h00);
        rd(8'h61, 8'h00);
        idle(2);
        `CHK(SRC_CRYSTAL_REFERENCE_EN_O, 1'b1)
        complete_run();
    end
endmodule
